// >>> hdl/adcctl_pkg.sv
// Shared constants, types and helpers for the converter control block
package adcctl_pkg;
  // Register offsets on the plain register port
  localparam logic [1:0] ADDR_CTRL = 2'h0;
  localparam logic [1:0] ADDR_RESULT = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  // Field positions in the control and status registers
  localparam int CTRL_ON_BIT = 0;
  localparam int CTRL_GO_BIT = 1;
  localparam int CTRL_CHAN_LSB = 2;
  localparam int CTRL_CLK_LSB = 5;
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_BUSY_BIT = 1;
  // Values after reset
  localparam logic [7:0] RESULT_RST = 8'h00;
  localparam logic [7:0] DATA_ZERO = 8'h00;
  localparam logic [4:0] CHAN_ONEHOT_RST = 5'h01;
  // Half bit periods: 19 halves make 9.5 bit periods
  localparam logic [4:0] HALF_TOTAL = 5'h13;
  localparam logic [4:0] HALF_FIRST_DECIDE = 5'h02;
  localparam logic [4:0] HALF_LAST_DECIDE = 5'h10;
  // Half count in the final half period, and last one with a successor
  localparam logic [4:0] HALF_PRE_LAST = 5'h12;
  localparam logic [4:0] HALF_RATE_END = 5'h11;
  localparam logic [4:0] HALF_ZERO = 5'h00;
  localparam logic [7:0] SAR_MSB = 8'h80;

  // Conversion clock sources; code 3'b111 is illegal
  typedef enum logic [2:0] {
    CLK_DIV2 = 3'b000,
    CLK_DIV4 = 3'b001,
    CLK_DIV8 = 3'b010,
    CLK_DIV16 = 3'b011,
    CLK_DIV32 = 3'b100,
    CLK_DIV64 = 3'b101,
    CLK_RC = 3'b110
  } adcctl_clk_e;

  // Sample-and-hold sources; codes above 3'b100 are illegal
  typedef enum logic [2:0] {
    CH_PIN0 = 3'b000,
    CH_PIN1 = 3'b001,
    CH_PIN2 = 3'b010,
    CH_TEMP = 3'b011,
    CH_FIXREF = 3'b100
  } adcctl_chan_e;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_CONV = 1'b1
  } adcctl_state_e;

  // Software-visible configuration
  typedef struct packed {
    adcctl_clk_e clk_sel;
    adcctl_chan_e chan;
    logic on;
  } adcctl_ctrl_s;

  localparam adcctl_ctrl_s CTRL_RST = '{CLK_DIV2, CH_PIN0, 1'b0};

  // System clocks per half conversion-clock period, minus one
  function automatic logic [4:0] half_period_m1(input adcctl_clk_e sel);
    logic [4:0] r;
    r = 5'h00;
    case (sel)
      CLK_DIV4: r = 5'h01;
      CLK_DIV8: r = 5'h03;
      CLK_DIV16: r = 5'h07;
      CLK_DIV32: r = 5'h0F;
      CLK_DIV64: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction : half_period_m1
endpackage : adcctl_pkg

// >>> hdl/adcctl_clkgen.sv
// Conversion clock half-period tick generator
`timescale 1ns/1ns
module adcctl_clkgen import adcctl_pkg::*; (
  input wire logic ref_clk_i, // System clock
  input wire logic arst_n_i, // Async reset, active low
  input wire adcctl_clk_e clk_sel_i, // Conversion clock source
  input wire logic restart_i, // Realign divider at conversion start
  input wire logic rc_clk_i, // Dedicated RC oscillator, async
  output logic half_tick_o, // One pulse per half conversion clock
  output logic rc_edge_o // Synchronised RC edge seen
);
  logic [2:0] sync;
  logic [4:0] cnt;
  logic [2:0] next_sync;
  logic [4:0] next_cnt;
  logic next_tick;

  // Only the last two sync stages feed the edge detector
  assign rc_edge_o = sync[2] ^ sync[1];

  // Divider follows the system clock; the RC source ignores it
  always_comb
  begin
    next_sync = {sync[1:0], rc_clk_i};
    next_cnt = 5'(cnt + 5'h01);
    next_tick = 1'b0;
    if (restart_i)
    begin
      next_cnt = 5'h00;
    end
    else if (clk_sel_i == CLK_RC)
    begin
      next_cnt = 5'h00;
      next_tick = rc_edge_o;
    end
    else if (cnt >= half_period_m1(clk_sel_i))
    begin
      next_cnt = 5'h00;
      next_tick = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      sync <= 3'h0;
      cnt <= 5'h00;
      half_tick_o <= 1'b0;
    end
    else
    begin
      sync <= next_sync;
      cnt <= next_cnt;
      half_tick_o <= next_tick;
    end
  end
endmodule : adcctl_clkgen

// >>> hdl/adcctl_top.sv
// Converter control: configuration, source select and SAR sequencing
// How it works
// - Exactly one of five sources reaches sample-and-hold
// - Reference is always the supply, never external
// - Seven clock sources: system clock dividers, RC
// - Bit period derives from selected conversion clock
// - Full conversion lasts nine and half periods
// - Divided clocks track system clock; RC independent
`timescale 1ns/1ns
module adcctl_top import adcctl_pkg::*; (
  input wire logic ref_clk_i, // System clock, 100 MHz
  input wire logic arst_n_i, // Async reset, active low
  input wire logic [1:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, cycle after strobe
  input wire logic rc_clk_i, // Dedicated RC oscillator pin
  input wire logic cmp_i, // Comparator: input above DAC code
  output logic [4:0] chan_sel_o, // One-hot sample-and-hold source
  output logic ref_supply_o, // Reference tied to supply
  output logic [7:0] dac_code_o, // SAR trial code
  output logic busy_o, // Conversion in progress
  output logic done_o // Sticky completion flag
);
  adcctl_ctrl_s ctrl, next_ctrl;
  adcctl_state_e state, next_state;
  logic [4:0] half_cnt, next_half_cnt;
  logic [7:0] mask, next_mask;
  logic [7:0] next_sar, result, next_result;
  logic next_done, next_busy;
  logic [7:0] next_rdata;
  logic [4:0] next_chan_sel;
  logic [1:0] cmp_s;
  logic half_tick, rc_edge, start, ctrl_wr, stat_wr;
  logic [4:0] k;
  adcctl_clk_e wr_clk;
  adcctl_chan_e wr_chan;

  // Tick source; divider realigned at each start so divided-clock timing counts from go
  adcctl_clkgen u_clkgen (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clk_sel_i(ctrl.clk_sel),
    .restart_i(start),
    .rc_clk_i(rc_clk_i),
    .half_tick_o(half_tick),
    .rc_edge_o(rc_edge)
  );

  // Write decode
  assign ctrl_wr = wr_i && (addr_i == ADDR_CTRL);
  assign stat_wr = wr_i && (addr_i == ADDR_STATUS);
  assign wr_clk = adcctl_clk_e'(wdata_i[CTRL_CLK_LSB +: 3]);
  assign wr_chan = adcctl_chan_e'(wdata_i[CTRL_CHAN_LSB +: 3]);
  assign start = ctrl_wr && wdata_i[CTRL_GO_BIT] && wdata_i[CTRL_ON_BIT]
    && (state == ST_IDLE);
  assign k = 5'(half_cnt + 5'h01);

  // Configuration; sources locked while converting to keep the
  // selected input and clock steady under the running result
  always_comb
  begin
    next_ctrl = ctrl;
    if (ctrl_wr)
    begin
      next_ctrl.on = wdata_i[CTRL_ON_BIT];
      if (state == ST_IDLE)
      begin
        if (wr_clk != 3'b111)
        begin
          next_ctrl.clk_sel = wr_clk;
        end
        if (wr_chan <= CH_FIXREF)
        begin
          next_ctrl.chan = wr_chan;
        end
      end
    end
    next_chan_sel = 5'(5'h01 << next_ctrl.chan);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      ctrl <= CTRL_RST;
      chan_sel_o <= CHAN_ONEHOT_RST;
      ref_supply_o <= 1'b1;
    end
    else
    begin
      ctrl <= next_ctrl;
      chan_sel_o <= next_chan_sel;
      ref_supply_o <= 1'b1;
    end
  end

  // Comparator crosses from the analog side: two flops first
  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      cmp_s <= 2'h0;
    end
    else
    begin
      cmp_s <= {cmp_s[0], cmp_i};
    end
  end

  // SAR sequencer: two half ticks per bit period
  always_comb
  begin
    next_state = state;
    next_half_cnt = half_cnt;
    next_mask = mask;
    next_sar = dac_code_o;
    next_result = result;
    next_done = done_o;
    if (stat_wr && wdata_i[STAT_DONE_BIT])
    begin
      next_done = 1'b0;
    end
    unique case (state)
      ST_IDLE:
      begin
        if (start)
        begin
          next_state = ST_CONV;
          next_half_cnt = HALF_ZERO;
          next_mask = SAR_MSB;
          next_sar = SAR_MSB;
        end
      end
      ST_CONV:
      begin
        if (!next_ctrl.on)
        begin
          // Turning off aborts without a result
          next_state = ST_IDLE;
        end
        else if (half_tick)
        begin
          next_half_cnt = k;
          if (!k[0] && k >= HALF_FIRST_DECIDE && k <= HALF_LAST_DECIDE)
          begin
            // Keep bit if input above trial, then try next bit
            next_sar = (cmp_s[1] ? dac_code_o : dac_code_o & ~mask)
              | (mask >> 1);
            next_mask = mask >> 1;
          end
          if (k == HALF_TOTAL)
          begin
            next_state = ST_IDLE;
            next_result = dac_code_o;
            next_done = 1'b1;
          end
        end
      end
    endcase
    next_busy = (next_state == ST_CONV);
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      state <= ST_IDLE;
      half_cnt <= HALF_ZERO;
      mask <= DATA_ZERO;
      dac_code_o <= DATA_ZERO;
      result <= RESULT_RST;
      done_o <= 1'b0;
      busy_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      half_cnt <= next_half_cnt;
      mask <= next_mask;
      dac_code_o <= next_sar;
      result <= next_result;
      done_o <= next_done;
      busy_o <= next_busy;
    end
  end

  // Read mux; unmapped address reads zero
  always_comb
  begin
    next_rdata = DATA_ZERO;
    if (rd_i)
    begin
      unique case (addr_i)
        ADDR_CTRL: next_rdata = {ctrl.clk_sel, ctrl.chan, busy_o, ctrl.on};
        ADDR_RESULT: next_rdata = result;
        ADDR_STATUS: next_rdata = {6'h00, busy_o, done_o};
        default: next_rdata = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rdata_o <= DATA_ZERO;
    end
    else
    begin
      rdata_o <= next_rdata;
    end
  end

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!arst_n_i);

  sequence s_last_half;
    busy_o && ctrl.on && half_tick && half_cnt == HALF_PRE_LAST;
  endsequence

  sequence s_div8_gap;
    !half_tick [*3] ##1 half_tick;
  endsequence

  a_chan_onehot: assert property ($onehot(chan_sel_o))
    else $error("source select not one-hot");
  a_ref_supply: assert property (##1 ref_supply_o)
    else $error("reference left the supply");
  a_div2_rate: assert property (busy_o && ctrl.clk_sel == CLK_DIV2
    && half_tick && half_cnt < HALF_RATE_END |=> half_tick)
    else $error("divide-by-2 tick missing");
  a_div8_rate: assert property (busy_o && ctrl.clk_sel == CLK_DIV8
    && half_tick && half_cnt < HALF_RATE_END |=> s_div8_gap)
    else $error("divide-by-8 tick spacing wrong");
  a_bit_on_period: assert property (busy_o && $past(busy_o)
    && $changed(dac_code_o) |-> $past(half_tick) && $past(half_cnt[0]))
    else $error("trial code moved off a period edge");
  a_conv_length: assert property ($fell(busy_o) && ctrl.on
    |-> $past(half_cnt) == HALF_PRE_LAST && $past(half_tick))
    else $error("conversion not 19 half periods");
  a_rc_follow: assert property (busy_o && ctrl.clk_sel == CLK_RC
    && half_tick |-> $past(rc_edge))
    else $error("RC tick without oscillator edge");
  a_done_result: assert property (s_last_half
    |=> !busy_o && done_o && result == $past(dac_code_o))
    else $error("completion did not store result");
endmodule : adcctl_top

// >>> tb/adcctl_analog.sv
// Analog sources and RC oscillator facing the converter control
`timescale 1ns/1ns
module adcctl_analog (
  input wire logic ref_clk_i, // System clock
  input wire logic [4:0] chan_sel_i, // One-hot source select
  input wire logic [7:0] dac_code_i, // SAR trial code
  input wire logic [39:0] level_i, // Five source levels
  output logic cmp_o, // High while input above trial code
  output logic rc_clk_o // Free-running RC oscillator
);
  logic flip = 1'b0;
  // Pins taken as analog inputs, set up so by software beforehand
  // Input sits half a step above its level, so level >= code wins
  always_comb
  begin
    cmp_o = flip; // No single source: comparator sees noise
    for (int k = 0; k < 5; k++)
      if (chan_sel_i == 5'(1 << k))
        cmp_o = (level_i[k*8 +: 8] >= dac_code_i);
  end
  // Changing pattern, so a floating input never looks stable
  always @(posedge ref_clk_i)
    flip <= ~flip;
  // Oscillator free of the system clock
  initial
  begin
    rc_clk_o = 1'b0;
    forever #170 rc_clk_o = ~rc_clk_o;
  end
endmodule : adcctl_analog

// >>> tb/tb_adcctl_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_adcctl_top;
  import adcctl_pkg::*;
  logic ref_clk_i, arst_n_i, wr_i, rd_i, cmp_i, rc_clk_i;
  logic ref_supply_o, busy_o, done_o;
  logic [1:0] addr_i;
  logic [7:0] wdata_i, rdata_o, dac_code_o, v;
  logic [4:0] chan_sel_o;
  logic [39:0] level;
  int fails = 0;
  int samples_checked = 0;
  int lv[5];
  int exp_q[$];
  int ctrl_m;

  adcctl_top i_adcctl_top (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .rc_clk_i(rc_clk_i), .cmp_i(cmp_i),
    .chan_sel_o(chan_sel_o), .ref_supply_o(ref_supply_o),
    .dac_code_o(dac_code_o), .busy_o(busy_o), .done_o(done_o));
  adcctl_analog i_adcctl_analog (.ref_clk_i(ref_clk_i),
    .chan_sel_i(chan_sel_o), .dac_code_i(dac_code_o), .level_i(level),
    .cmp_o(cmp_i), .rc_clk_o(rc_clk_i));

  // 100 MHz system clock
  initial
  begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
    input string what);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [7:0] d);
    @(posedge ref_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // One conversion; edges from start to done are 19*N/2+1 for /N
  task automatic conv(input int c, input int ch);
    int n;
    int lim;
    lim = (c == 6) ? 4000 : 19 * (1 << c) + 1;
    ctrl_m = (c << 5) | (ch << 2) | 1;
    wr(ADDR_CTRL, 8'(ctrl_m));
    repeat (8) @(posedge ref_clk_i);
    chk(16'(chan_sel_o), 16'(1 << ch), "source");
    exp_q.push_back(lv[ch]);
    wr(ADDR_CTRL, 8'(ctrl_m | 2));
    #1 n = 0;
    chk(16'(busy_o), 16'h0001, "busy");
    chk(16'(dac_code_o), 16'(SAR_MSB), "first trial");
    while (done_o !== 1'b1 && n < lim + 9)
    begin
      @(posedge ref_clk_i);
      #1 n++;
    end
    if (c == 6)
      chk(16'(done_o), 16'h0001, "rc done");
    else
      chk(16'(n), 16'(lim), "duration");
    chk(16'(busy_o), 16'h0000, "busy end");
    rd(ADDR_RESULT, v);
    chk(16'(v), 16'(exp_q.pop_front()), "result");
    rd(ADDR_CTRL, v);
    chk(16'(v), 16'(ctrl_m), "ctrl");
    rd(ADDR_STATUS, v);
    chk(16'(v), 16'h0001, "done flag");
    wr(ADDR_STATUS, 8'h01);
    rd(ADDR_STATUS, v);
    chk(16'(v), 16'h0000, "done clear");
    $display("test conv clk %0d chan %0d done", c, ch);
  endtask : conv

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  // Main sequence
  initial
  begin
    arst_n_i = 1'b0;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 2'h0;
    wdata_i = 8'h00;
    level = '0;
    void'($urandom(4698));
    lv[0] = 255;
    lv[1] = 0;
    for (int k = 2; k < 5; k++)
      lv[k] = $urandom_range(255);
    for (int k = 0; k < 5; k++)
      level[k*8 +: 8] = 8'(lv[k]);
    repeat (16) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    #1 chk(16'(chan_sel_o), 16'h0001, "reset source");
    chk(16'(ref_supply_o), 16'h0001, "reference");
    rd(ADDR_RESULT, v);
    chk(16'(v), 16'(RESULT_RST), "reset result");
    rd(ADDR_CTRL, v);
    chk(16'(v), 16'h0000, "reset ctrl");
    $display("test reset done");
    for (int c = 0; c < 7; c++)
      conv(c, (c < 5) ? c : $urandom_range(4));
    chk(16'(ref_supply_o), 16'h0001, "reference");
    // Illegal clock and source codes leave the old setting
    wr(ADDR_CTRL, 8'(ctrl_m | 8'hE0));
    rd(ADDR_CTRL, v);
    chk(16'(v), 16'(ctrl_m), "bad clock");
    for (int k = 5; k < 8; k++)
    begin
      wr(ADDR_CTRL, 8'((ctrl_m & 8'hE3) | (k << 2)));
      rd(ADDR_CTRL, v);
      chk(16'(v), 16'(ctrl_m), "bad source");
    end
    wr(2'h3, 8'hFF);
    rd(2'h3, v);
    chk(16'(v), 16'h0000, "unmapped");
    $display("test refusals done");
    // Source change while busy is ignored, then abort
    wr(ADDR_CTRL, 8'hA9);
    repeat (8) @(posedge ref_clk_i);
    wr(ADDR_CTRL, 8'hAB);
    repeat (20) @(posedge ref_clk_i);
    wr(ADDR_CTRL, 8'hA1);
    #1 chk(16'(chan_sel_o), 16'h0004, "busy source");
    chk(16'(busy_o), 16'h0001, "still busy");
    wr(ADDR_CTRL, 8'hA0);
    repeat (1300) @(posedge ref_clk_i);
    #1 chk(16'({busy_o, done_o}), 16'h0000, "abort");
    $display("test abort done");
    give_verdict();
  end

  // Watchdog well beyond the planned run
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    fails++;
    give_verdict();
  end
endmodule : tb_adcctl_top
